//--- src/urx_defines.svh
// Register offsets, field positions, reset values and counts of the receiver.
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH

`define URX_ADDR_W        12
`define URX_OFF_MODE      12'h000
`define URX_OFF_COMMAND   12'h004
`define URX_OFF_STATUS    12'h008
`define URX_OFF_INTSTAT   12'h00C
`define URX_OFF_DATA      12'h010
`define URX_OFF_INTMASK   12'h014
`define URX_OFF_DIVISOR   12'h018

`define URX_MODE_RST      6'h00
`define URX_MODE_X16      0
`define URX_MODE_LEN_LO   1
`define URX_MODE_LEN_HI   2
`define URX_MODE_PAR_EN   3
`define URX_MODE_PAR_ODD  4
`define URX_MODE_WAKE     5

`define URX_CMD_ENABLE    0
`define URX_CMD_DISABLE   1
`define URX_CMD_RESET     2
`define URX_CMD_ERR_RST   3

`define URX_MASK_RST      3'h0
`define URX_MASK_CHAR     0
`define URX_MASK_BRK      1
`define URX_MASK_GP       2

`define URX_DIV_RST       16'h0000

`define URX_DEPTH         256
`define URX_PTR_W         8
`define URX_LEN_BASE      3'h4
`define URX_HALF_TICK     4'h7
`define URX_LAST_TICK     4'hF

`endif

//--- src/urx_pkg.sv
// Types shared by the serial receiver.
package urx_pkg;

  typedef enum logic [6:0] {
    URX_IDLE  = 7'b000_0001,
    URX_START = 7'b000_0010,
    URX_DATA  = 7'b000_0100,
    URX_PAR   = 7'b000_1000,
    URX_STOP  = 7'b001_0000,
    URX_FCHK  = 7'b010_0000,
    URX_BRK   = 7'b100_0000
  } urx_state_e;

  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } urx_entry_s;

endpackage

//--- src/urx_receiver.sv
// Serial receive channel with receive queue and APB register slave.
//
// The implementer's own choices: the address map and the APB slave port.
`include "urx_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module urx_receiver
  import urx_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`URX_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   serial_in,
  input  wire logic                   bit_rate_clock,
  output logic                        interrupt_request_n,
  output logic                        gp_pin_out
);

  urx_state_e              st_r;
  logic [5:0]              mode_r;
  logic [2:0]              mask_r;
  logic [15:0]             div_r;
  logic [15:0]             div_cnt_r;
  logic                    en_r;
  logic                    rxd_m_r;
  logic                    rxd_s_r;
  logic                    rxd_last_r;
  logic                    bclk_m_r;
  logic                    bclk_s_r;
  logic                    bclk_d_r;
  logic [3:0]              cnt_r;
  logic [2:0]              bitn_r;
  logic [7:0]              shreg_r;
  logic                    par_bit_r;
  logic                    hi_r;
  urx_entry_s              pend_r;
  logic                    pend_v_r;
  urx_entry_s              mem [`URX_DEPTH];
  logic [`URX_PTR_W-1:0]   wr_ptr_r;
  logic [`URX_PTR_W-1:0]   rd_ptr_r;
  logic [`URX_PTR_W:0]     count_r;
  logic                    overrun_r;
  logic                    brk_chg_r;
  logic                    x16;
  logic                    tick;
  logic                    bclk_rise;
  logic                    samp;
  logic                    fall;
  logic                    active;
  logic                    char_zero;
  logic                    done;
  logic                    is_break;
  logic                    brk_end;
  logic                    start_ok;
  logic                    full;
  logic                    empty;
  logic                    push;
  logic                    pop;
  logic                    setup;
  logic                    wr_acc;
  logic                    cmd_wr;
  logic                    err_rst;
  logic                    rx_rst;
  logic [2:0]              last_bit;
  urx_entry_s              entry;
  urx_entry_s              head;
  logic [1:0]              intstat;
  logic                    mapped;
  logic [31:0]             rdata;

  always_comb
  begin
    x16       = mode_r[`URX_MODE_X16];
    tick      = (div_cnt_r == div_r);
    bclk_rise = bclk_s_r & ~bclk_d_r;
    samp      = x16 ? (tick && cnt_r == `URX_LAST_TICK) : bclk_rise;
    fall      = rxd_last_r & ~rxd_s_r;
    active    = en_r | mode_r[`URX_MODE_WAKE];
    last_bit  = `URX_LEN_BASE + {1'b0, mode_r[`URX_MODE_LEN_HI:`URX_MODE_LEN_LO]};
    char_zero = (shreg_r == 8'h00) && !(mode_r[`URX_MODE_PAR_EN] && par_bit_r);
    done      = (st_r == URX_STOP) && samp;
    is_break  = done && char_zero && !rxd_s_r;
    brk_end   = (st_r == URX_BRK) && samp && rxd_s_r && hi_r;
    start_ok  = (st_r == URX_START || st_r == URX_FCHK) && !rxd_s_r &&
                (x16 ? (tick && cnt_r == `URX_HALF_TICK)
                     : bclk_rise);
    entry.brk = is_break;
    entry.fe  = done && !char_zero && !rxd_s_r;
    entry.pe  = !is_break && mode_r[`URX_MODE_PAR_EN] &&
                ((^shreg_r ^ par_bit_r) != mode_r[`URX_MODE_PAR_ODD]);
    entry.data = is_break ? 8'h00 : shreg_r;
    full      = (count_r == (`URX_PTR_W+1)'(`URX_DEPTH));
    empty     = (count_r == '0);
    push      = pend_v_r && !full;
    head      = mem[rd_ptr_r];
    setup     = psel && !penable;
    wr_acc    = psel && penable && pwrite;
    cmd_wr    = wr_acc && (paddr == `URX_OFF_COMMAND);
    err_rst   = cmd_wr && pwdata[`URX_CMD_ERR_RST];
    rx_rst    = cmd_wr && pwdata[`URX_CMD_RESET];
    pop       = psel && penable && !pwrite &&
                (paddr == `URX_OFF_DATA) && !empty;
    intstat   = {brk_chg_r, !empty};
  end

  assign pready = 1'b1;

  // Two stage synchronisers; the second stage feeds the logic, and a third stage delays it for edge detection.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_m_r    <= 1'b1;
      rxd_s_r    <= 1'b1;
      rxd_last_r <= 1'b1;
      bclk_m_r   <= 1'b0;
      bclk_s_r   <= 1'b0;
      bclk_d_r   <= 1'b0;
    end
    else
    begin
      rxd_m_r    <= serial_in;
      rxd_s_r    <= rxd_m_r;
      rxd_last_r <= rxd_s_r;
      bclk_m_r   <= bit_rate_clock;
      bclk_s_r   <= bclk_m_r;
      bclk_d_r   <= bclk_s_r;
    end
  end

  // Fast tick divider, restarted on a start edge so bit centres track it.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_cnt_r <= 16'h0000;
    else if ((st_r == URX_IDLE && fall) || tick)
      div_cnt_r <= 16'h0000;
    else
      div_cnt_r <= div_cnt_r + 16'h0001;
  end

  // Receive sequence.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r      <= URX_IDLE;
      cnt_r     <= 4'h0;
      bitn_r    <= 3'h0;
      shreg_r   <= 8'h00;
      par_bit_r <= 1'b0;
      hi_r      <= 1'b0;
    end
    else if (!active || rx_rst)
      st_r <= URX_IDLE;
    else
    begin
      if (tick && st_r != URX_IDLE)
        cnt_r <= cnt_r + 4'h1;
      if (start_ok)
      begin
        st_r      <= URX_DATA;
        cnt_r     <= 4'h0;
        bitn_r    <= 3'h0;
        shreg_r   <= 8'h00;
        par_bit_r <= 1'b0;
      end
      else
      begin
        case (st_r)
          URX_IDLE:
            if (fall)
            begin
              st_r  <= URX_START;
              cnt_r <= 4'h0;
            end
          URX_START, URX_FCHK:
            if ((x16 ? tick : bclk_rise) && rxd_s_r)
              st_r <= URX_IDLE;
          URX_DATA:
            if (samp)
            begin
              shreg_r[bitn_r] <= rxd_s_r;
              bitn_r          <= bitn_r + 3'h1;
              if (bitn_r == last_bit)
                st_r <= mode_r[`URX_MODE_PAR_EN] ? URX_PAR : URX_STOP;
            end
          URX_PAR:
            if (samp)
            begin
              par_bit_r <= rxd_s_r;
              st_r      <= URX_STOP;
            end
          URX_STOP:
            if (samp)
            begin
              hi_r <= 1'b0;
              if (is_break)
                st_r <= URX_BRK;
              else if (entry.fe)
                st_r <= URX_FCHK;
              else
                st_r <= URX_IDLE;
            end
          URX_BRK:
            if (samp)
            begin
              hi_r <= rxd_s_r;
              if (brk_end)
                st_r <= URX_IDLE;
            end
          default:
            st_r <= URX_IDLE;
        endcase
      end
    end
  end

  // Hold register between the shift register and the queue.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_r   <= '0;
      pend_v_r <= 1'b0;
    end
    else if (rx_rst)
      pend_v_r <= 1'b0;
    else if (done)
    begin
      pend_r   <= entry;
      pend_v_r <= 1'b1;
    end
    else if (push)
      pend_v_r <= 1'b0;
  end

  // Receive queue storage and pointers.
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr_r] <= pend_r;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else if (rx_rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end

  // Sticky conditions kept outside the queue; a set wins over a clear.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overrun_r <= 1'b0;
      brk_chg_r <= 1'b0;
    end
    else
    begin
      if (start_ok && pend_v_r && full)
        overrun_r <= 1'b1;
      else if (err_rst || rx_rst)
        overrun_r <= 1'b0;
      if (is_break || brk_end)
        brk_chg_r <= 1'b1;
      else if (err_rst)
        brk_chg_r <= 1'b0;
    end
  end

  // Software registers.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= `URX_MODE_RST;
      mask_r <= `URX_MASK_RST;
      div_r  <= `URX_DIV_RST;
      en_r   <= 1'b0;
    end
    else
    begin
      if (wr_acc && paddr == `URX_OFF_MODE)
        mode_r <= pwdata[5:0];
      if (wr_acc && paddr == `URX_OFF_INTMASK)
        mask_r <= pwdata[2:0];
      if (wr_acc && paddr == `URX_OFF_DIVISOR)
        div_r <= pwdata[15:0];
      if (rx_rst || (cmd_wr && pwdata[`URX_CMD_DISABLE]))
        en_r <= 1'b0;
      else if (cmd_wr && pwdata[`URX_CMD_ENABLE])
        en_r <= 1'b1;
    end
  end

  always_comb
  begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (paddr)
      `URX_OFF_MODE:    rdata = {26'h000_0000, mode_r};
      `URX_OFF_COMMAND: rdata = 32'h0000_0000;
      `URX_OFF_STATUS:  rdata = {24'h00_0000, head.brk & ~empty,
                                 head.fe & ~empty, head.pe & ~empty,
                                 overrun_r, 1'b0, en_r, full, ~empty};
      `URX_OFF_INTSTAT: rdata = {30'h0000_0000, intstat};
      `URX_OFF_DATA:    rdata = {24'h00_0000, empty ? 8'h00 : head.data};
      `URX_OFF_INTMASK: rdata = {29'h0000_0000, mask_r};
      `URX_OFF_DIVISOR: rdata = {16'h0000, div_r};
      default:          mapped = 1'b0;
    endcase
  end

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata;
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interrupt_request_n <= 1'b1;
      gp_pin_out          <= 1'b0;
    end
    else
    begin
      interrupt_request_n <= !(active && |(intstat & mask_r[1:0]));
      gp_pin_out          <= active && mask_r[`URX_MASK_GP] && !empty;
    end
  end

endmodule

`default_nettype wire

//--- tb/urx_receiver_chk.sv
// Port checker for the serial receiver, bound into the design.
`include "urx_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module urx_receiver_chk
  import urx_pkg::*;
(
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`URX_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  input wire logic                   serial_in,
  input wire logic                   bit_rate_clock,
  input wire logic                   interrupt_request_n,
  input wire logic                   gp_pin_out
);
  logic       acc, wr_cmd, rd_st, rd_is, rd_dat;
  logic       en_r, low_r, brk_r, ovr_r;
  logic [5:0] mode_r;
  assign acc = psel && penable;
  assign wr_cmd = acc && pwrite && paddr == `URX_OFF_COMMAND;
  assign rd_st = acc && !pwrite && paddr == `URX_OFF_STATUS;
  assign rd_is = acc && !pwrite && paddr == `URX_OFF_INTSTAT;
  assign rd_dat = acc && !pwrite && paddr == `URX_OFF_DATA;

  // Shadow of what software has set, what it has already seen and whether the line has been low.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= 6'h00;
    else if (acc && pwrite && paddr == `URX_OFF_MODE)
      mode_r <= pwdata[5:0];
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      en_r <= 1'b0;
    else if (wr_cmd && (pwdata[`URX_CMD_DISABLE] || pwdata[`URX_CMD_RESET]))
      en_r <= 1'b0;
    else if (wr_cmd && pwdata[`URX_CMD_ENABLE])
      en_r <= 1'b1;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      low_r <= 1'b0;
    else if (!serial_in)
      low_r <= 1'b1;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      brk_r <= 1'b0;
    else if (wr_cmd && pwdata[`URX_CMD_ERR_RST])
      brk_r <= 1'b0;
    else if (rd_is && prdata[1])
      brk_r <= 1'b1;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ovr_r <= 1'b0;
    else if (wr_cmd && (pwdata[`URX_CMD_ERR_RST] || pwdata[`URX_CMD_RESET]))
      ovr_r <= 1'b0;
    else if (rd_st && prdata[4])
      ovr_r <= 1'b1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_pready_high: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (acc && paddr > `URX_OFF_DIVISOR
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_reset_quiet: assert property ($rose(rst_n)
    |-> interrupt_request_n && !gp_pin_out)
    else $error("outputs active after reset");
  a_disabled_quiet: assert property (!en_r && !mode_r[5]
    |=> interrupt_request_n)
    else $error("disabled receiver interrupts");
  a_idle_no_char: assert property (!low_r && (rd_st || rd_is)
    |-> !prdata[0])
    else $error("character without start edge");
  a_brkchg_sticky: assert property (brk_r && rd_is |-> prdata[1])
    else $error("break change cleared early");
  a_overrun_sticky: assert property (ovr_r && rd_st |-> prdata[4])
    else $error("overrun cleared early");
  a_upper_zero: assert property (rd_dat
    |-> (prdata[7:0] >> (mode_r[2:1] + 4'd5)) == 8'h00)
    else $error("unused data bits not zero");
  a_brk_no_fe: assert property (rd_st && prdata[7]
    |-> !prdata[6] && !prdata[5])
    else $error("error flag on break character");

  c_overrun: cover property (rd_st && prdata[4]);
  c_break: cover property (rd_st && prdata[7]);
  c_brkchg: cover property (rd_is && prdata[1]);
  c_irq: cover property (!interrupt_request_n);
endmodule

bind urx_receiver urx_receiver_chk urx_receiver_chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .serial_in(serial_in),
  .bit_rate_clock(bit_rate_clock), .gp_pin_out(gp_pin_out),
  .interrupt_request_n(interrupt_request_n));
`default_nettype wire

//--- tb/urx_line_model.sv
// Behavioural model of the remote serial transmitter on the receive line.
`timescale 1ns/1ps
`default_nettype none

module urx_line_model
  import urx_pkg::*;
#(
  parameter int BIT_CYC = 16
)
(
  input  wire logic ref_clk,
  output var  logic serial_in
);
  initial serial_in = 1'b1;

  task automatic hold_level(input logic lvl, input int cyc);
    serial_in <= lvl;
    repeat (cyc) @(posedge ref_clk);
  endtask

  // A low stop bit is cut short so the line is high before a retry check.
  task automatic send(input logic [7:0] d, input int nbits, input logic par,
                      input logic flip, input logic stop);
    int i;
    hold_level(1'b0, BIT_CYC);
    for (i = 0; i < nbits; i++)
      hold_level(d[i], BIT_CYC);
    if (par)
      hold_level((^d) ^ flip, BIT_CYC);
    hold_level(stop, 12);
    hold_level(1'b1, BIT_CYC + 4);
  endtask
endmodule
`default_nettype wire

//--- tb/uart_serial_receiver_bench.sv
// Register level testbench of the serial receiver.
`include "urx_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_serial_receiver_bench
  import urx_pkg::*;
;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        serial_in, interrupt_request_n, gp_pin_out, er_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0]  brc_cnt = 4'h0;
  int          err_total, samples_checked, cycle_cnt, i;

  urx_receiver urx_receiver_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .serial_in(serial_in), .bit_rate_clock(brc_cnt[3]),
    .interrupt_request_n(interrupt_request_n), .gp_pin_out(gp_pin_out));
  urx_line_model urx_line_model_i (.ref_clk(ref_clk), .serial_in(serial_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    brc_cnt <= brc_cnt + 4'h1;
    cycle_cnt++;
    if (cycle_cnt > 80000)
    begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_v, exp);
  endtask

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(`URX_OFF_MODE, 32'h0000_0000);
    rdchk(`URX_OFF_INTMASK, 32'h0000_0000);
    rdchk(`URX_OFF_DIVISOR, 32'h0000_0000);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk({31'h0, er_v}, 32'h0000_0001);
    // Eight bits, even parity, 16x sampling, char and gp pin enabled.
    apb(1'b1, `URX_OFF_MODE, 32'h0000_000F);
    apb(1'b1, `URX_OFF_INTMASK, 32'h0000_0005);
    apb(1'b1, `URX_OFF_COMMAND, 32'h0000_0001);
    rdchk(`URX_OFF_STATUS, 32'h0000_0004);
    urx_line_model_i.send(8'hA5, 8, 1'b1, 1'b0, 1'b1);
    rdchk(`URX_OFF_STATUS, 32'h0000_0005);
    rdchk(`URX_OFF_INTSTAT, 32'h0000_0001);
    chk({30'h0, interrupt_request_n, gp_pin_out}, 32'h0000_0001);
    rdchk(`URX_OFF_DATA, 32'h0000_00A5);
    rdchk(`URX_OFF_STATUS, 32'h0000_0004);
    urx_line_model_i.hold_level(1'b0, 4);
    urx_line_model_i.hold_level(1'b1, 40);
    rdchk(`URX_OFF_STATUS, 32'h0000_0004);
    urx_line_model_i.send(8'h3C, 8, 1'b1, 1'b1, 1'b1);
    rdchk(`URX_OFF_STATUS, 32'h0000_0025);
    rdchk(`URX_OFF_DATA, 32'h0000_003C);
    urx_line_model_i.send(8'h81, 8, 1'b1, 1'b0, 1'b0);
    rdchk(`URX_OFF_STATUS, 32'h0000_0045);
    rdchk(`URX_OFF_DATA, 32'h0000_0081);
    urx_line_model_i.hold_level(1'b0, 480);
    urx_line_model_i.hold_level(1'b1, 64);
    rdchk(`URX_OFF_STATUS, 32'h0000_0085);
    rdchk(`URX_OFF_INTSTAT, 32'h0000_0003);
    rdchk(`URX_OFF_DATA, 32'h0000_0000);
    rdchk(`URX_OFF_INTSTAT, 32'h0000_0002);
    apb(1'b1, `URX_OFF_COMMAND, 32'h0000_0008);
    rdchk(`URX_OFF_INTSTAT, 32'h0000_0000);
    apb(1'b1, `URX_OFF_MODE, 32'h0000_0001);
    urx_line_model_i.send(8'hFF, 5, 1'b0, 1'b0, 1'b1);
    rdchk(`URX_OFF_DATA, 32'h0000_001F);
    // Bit clock mode; frame started so each bit clock rise is mid bit.
    apb(1'b1, `URX_OFF_MODE, 32'h0000_0006);
    @(posedge ref_clk iff brc_cnt == 4'h0);
    urx_line_model_i.send(8'h5A, 8, 1'b0, 1'b0, 1'b1);
    rdchk(`URX_OFF_DATA, 32'h0000_005A);
    // Fill the queue and the hold, then one more to overrun.
    apb(1'b1, `URX_OFF_MODE, 32'h0000_0007);
    for (i = 0; i < 258; i++)
      urx_line_model_i.send(i[7:0], 8, 1'b0, 1'b0, 1'b1);
    rdchk(`URX_OFF_STATUS, 32'h0000_0017);
    rdchk(`URX_OFF_DATA, 32'h0000_0000);
    apb(1'b1, `URX_OFF_COMMAND, 32'h0000_0008);
    rdchk(`URX_OFF_STATUS, 32'h0000_0007);
    for (i = 1; i < 256; i++)
      rdchk(`URX_OFF_DATA, {24'h0, i[7:0]});
    rdchk(`URX_OFF_DATA, 32'h0000_0001);
    rdchk(`URX_OFF_STATUS, 32'h0000_0004);
    apb(1'b1, `URX_OFF_INTMASK, 32'h0000_0001);
    apb(1'b1, `URX_OFF_COMMAND, 32'h0000_0002);
    urx_line_model_i.send(8'h55, 8, 1'b0, 1'b0, 1'b1);
    chk({31'h0, interrupt_request_n}, 32'h0000_0001);
    rdchk(`URX_OFF_STATUS, 32'h0000_0000);
    conclude();
  end
endmodule
`default_nettype wire
